// ==== logic/cdpc_pkg.sv ====
// Package of register map, field layout, keys and reset values for the clock control block
package cdpc_pkg;
    localparam logic [7:0] CDPC_OFS_CLOCK_DIVIDER_CONTROL = 8'h00;
    localparam logic [7:0] CDPC_OFS_OSCCTL = 8'h04;
    localparam logic [7:0] CDPC_OFS_REFCTL = 8'h08;
    localparam logic [7:0] CDPC_OFS_PWRCTL = 8'h0C;
    localparam logic [7:0] CDPC_OFS_STATUS = 8'h10;

    localparam int CDPC_ROI_BIT = 15;
    localparam int CDPC_DOZE_LSB = 12;
    localparam int CDPC_CPU_SLOWDOWN_ENABLE_BIT = 11;
    localparam int CDPC_FAST_RC_POSTSCALE_LSB = 8;
    localparam int CDPC_ACTIVE_SOURCE_SELECT_LSB = 12;
    localparam int CDPC_NOSC_LSB = 8;
    localparam int CDPC_LOCK_BIT = 5;
    localparam int CDPC_SWITCH_REQUEST_BIT = 0;
    localparam int CDPC_REFCLK_OUT_ENABLE_BIT = 15;
    localparam int CDPC_REFCLK_SLEEP_KEEP_BIT = 13;
    localparam int CDPC_REFCLK_SOURCE_SELECT_BIT = 12;
    localparam int CDPC_REFCLK_DIVIDER_LSB = 8;
    localparam int CDPC_IDLE_BIT = 0;
    localparam int CDPC_SLEEP_BIT = 1;
    localparam int CDPC_PRIMODE_BIT = 2;
    localparam int CDPC_WDTEN_BIT = 3;
    localparam int CDPC_FSCMEN_BIT = 4;

    localparam logic [2:0] CDPC_DOZE_RST = 3'h3;
    localparam logic [2:0] CDPC_FAST_RC_POSTSCALE_RST = 3'h1;
    localparam logic [2:0] CDPC_SRC_RST = 3'h7;

    localparam logic [7:0] CDPC_KEY_H1 = 8'h78;
    localparam logic [7:0] CDPC_KEY_H2 = 8'h9A;
    localparam logic [7:0] CDPC_KEY_L1 = 8'h46;
    localparam logic [7:0] CDPC_KEY_L2 = 8'h57;

    localparam logic [2:0] CDPC_SRC_FRC = 3'h7;
    localparam logic [2:0] CDPC_SRC_FRC500 = 3'h6;

    // Switch settle time in cycles, models oscillator start-up
    localparam logic [7:0] CDPC_SWITCH_CYCLES = 8'h10;

    typedef enum logic [1:0] {
        CDPC_RUN = 2'b00,
        CDPC_IDLE = 2'b01,
        CDPC_SLEEP = 2'b10
    } cdpc_pmode_t;
endpackage

// ==== logic/cdpc_divider.sv ====
// Power-of-two clock-enable divider used for doze and postscaler
`timescale 1ns/1ps
module cdpc_divider #(
    parameter int WIDTH = 16
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic run,
    input wire logic [WIDTH-1:0] mask,
    output logic tick,
    output logic level
);
    logic [WIDTH-1:0] count;

    if (WIDTH < 2) begin
        $error("cdpc_divider: WIDTH too small");
    end

    // A tick each time the low bits under mask wrap; mask 0 ticks every cycle
    assign tick = run && ((count & mask) == mask);

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            count <= '0;
            level <= 1'b0;
        end else if (!run) begin
            count <= '0;
            level <= 1'b0;
        end else begin
            count <= count + 1'b1;
            if (tick) begin
                level <= ~level;
            end
        end
    end
endmodule

// ==== logic/cdpc_top.sv ====
// Clock divider, keyed oscillator switch, reference output and idle control with APB slave
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module cdpc_top
    import cdpc_pkg::*;
#(
    parameter int DIV_WIDTH = 16
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic IRQ_EVENT,
    input wire logic WDT_TIMEOUT,
    input wire logic PLL_LOCK,
    input wire logic PRI_OSC_CLK,
    output logic CPU_CLK_EN,
    output logic PERIPH_CLK_EN,
    output logic REFCLK_OUT_PIN,
    output logic REFCLK_OUT_OE,
    output logic PRI_OSC_ON,
    output logic LOW_POWER_INTERNAL_RC_ON,
    output logic WDT_CLEAR,
    output logic WAKE_TO_ISR
);
    logic interrupt_speed_restore;
    logic [2:0] doze_ratio;
    logic cpu_slowdown_enable;
    logic [2:0] fast_rc_postscale;
    logic [2:0] active_source_select;
    logic [2:0] next_source_select;
    logic switch_request;
    logic refclk_out_enable;
    logic refclk_sleep_keep;
    logic refclk_source_select;
    logic [3:0] refclk_divider;
    logic primary_mode;
    logic wdt_enable;
    logic clock_fail_monitor_enable;
    cdpc_pmode_t pmode;
    logic irq_held;
    logic [1:0] hkey;
    logic [1:0] lkey;
    logic [7:0] switch_count;
    logic [2:0] pri_sync;
    logic [1:0] irq_sync;
    logic [1:0] wdt_sync;
    logic [1:0] lock_sync;
    logic irq_prev;

    if (DIV_WIDTH < 8 || DIV_WIDTH > 30) begin
        $error("cdpc_top: DIV_WIDTH out of range");
    end

    function automatic logic [DIV_WIDTH-1:0] pow2_mask(input logic [4:0] shift);
        pow2_mask = DIV_WIDTH'((32'h1 << shift) - 32'h1);
    endfunction

    // Bus decode
    wire wr_access = PSEL && PENABLE && PWRITE;
    wire rd_access = PSEL && PENABLE && !PWRITE;
    wire addr_clock_divider_control = PADDR == CDPC_OFS_CLOCK_DIVIDER_CONTROL;
    wire addr_oscctl = PADDR == CDPC_OFS_OSCCTL;
    wire addr_refctl = PADDR == CDPC_OFS_REFCTL;
    wire addr_pwrctl = PADDR == CDPC_OFS_PWRCTL;
    wire addr_status = PADDR == CDPC_OFS_STATUS;
    wire addr_ok = addr_clock_divider_control || addr_oscctl || addr_refctl || addr_pwrctl || addr_status;
    wire wr_clock_divider_control = wr_access && addr_clock_divider_control;
    wire wr_osc_hi = wr_access && addr_oscctl && PSTRB[1];
    wire wr_osc_lo = wr_access && addr_oscctl && PSTRB[0];
    wire wr_refctl = wr_access && addr_refctl;
    wire wr_pwrctl = wr_access && addr_pwrctl;
    wire [7:0] wr_hi = PWDATA[15:8];
    wire [7:0] wr_lo = PWDATA[7:0];

    // Synchronised external events
    wire irq_level = irq_sync[1];
    wire irq_rise = irq_level && !irq_prev;
    wire wdt_timeout = wdt_sync[1];
    wire pll_lock = lock_sync[1];

    // Key state: 0 idle, 1 first key seen, 2 unlocked for one write
    wire hi_unlocked = hkey == 2'd2;
    wire lo_unlocked = lkey == 2'd2;
    wire accept_nosc = wr_osc_hi && hi_unlocked;
    wire accept_osc_lo = wr_osc_lo && lo_unlocked;
    wire switch_done = switch_request && (switch_count == CDPC_SWITCH_CYCLES) && pll_lock;

    // Idle and wake
    wire power_save_instruction_idle = wr_pwrctl && PWDATA[CDPC_IDLE_BIT];
    wire power_save_instruction_sleep = wr_pwrctl && PWDATA[CDPC_SLEEP_BIT];
    wire wake_event = irq_rise || irq_held || wdt_timeout;
    wire asleep = pmode == CDPC_SLEEP;

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            irq_sync <= 2'b00;
            wdt_sync <= 2'b00;
            lock_sync <= 2'b00;
            irq_prev <= 1'b0;
        end else begin
            irq_sync <= {irq_sync[0], IRQ_EVENT};
            wdt_sync <= {wdt_sync[0], WDT_TIMEOUT};
            lock_sync <= {lock_sync[0], PLL_LOCK};
            irq_prev <= irq_level;
        end
    end

    // Divider register; the interrupt clear wins over a software write
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            interrupt_speed_restore <= 1'b0;
            doze_ratio <= CDPC_DOZE_RST;
            cpu_slowdown_enable <= 1'b0;
            fast_rc_postscale <= CDPC_FAST_RC_POSTSCALE_RST;
        end else begin
            if (wr_clock_divider_control) begin
                interrupt_speed_restore <= PWDATA[CDPC_ROI_BIT];
                doze_ratio <= PWDATA[CDPC_DOZE_LSB +: 3];
                cpu_slowdown_enable <= PWDATA[CDPC_CPU_SLOWDOWN_ENABLE_BIT];
                fast_rc_postscale <= PWDATA[CDPC_FAST_RC_POSTSCALE_LSB +: 3];
            end
            if (irq_rise && interrupt_speed_restore) begin
                cpu_slowdown_enable <= 1'b0;
            end
        end
    end

    // Keyed unlock of both oscillator control bytes
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            hkey <= 2'd0;
            lkey <= 2'd0;
        end else begin
            // Any bus write breaks a pending sequence: keys must be consecutive
            if (wr_access) begin
                hkey <= 2'd0;
                lkey <= 2'd0;
                if (wr_osc_hi && !wr_osc_lo) begin
                    if (hkey == 2'd0 && wr_hi == CDPC_KEY_H1) begin
                        hkey <= 2'd1;
                    end else if (hkey == 2'd1 && wr_hi == CDPC_KEY_H2) begin
                        hkey <= 2'd2;
                    end
                end
                if (wr_osc_lo && !wr_osc_hi) begin
                    if (lkey == 2'd0 && wr_lo == CDPC_KEY_L1) begin
                        lkey <= 2'd1;
                    end else if (lkey == 2'd1 && wr_lo == CDPC_KEY_L2) begin
                        lkey <= 2'd2;
                    end
                end
            end
        end
    end

    // Oscillator selection and switch
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            active_source_select <= CDPC_SRC_RST;
            next_source_select <= CDPC_SRC_RST;
            switch_request <= 1'b0;
            switch_count <= 8'h00;
        end else begin
            // Writes outside the unlocked slot are dropped
            if (accept_nosc) begin
                next_source_select <= wr_hi[2:0];
            end
            if (switch_done) begin
                switch_request <= 1'b0;
                active_source_select <= next_source_select;
                switch_count <= 8'h00;
            end else if (switch_request) begin
                if (switch_count != CDPC_SWITCH_CYCLES) begin
                    switch_count <= switch_count + 8'h01;
                end
            end else if (accept_osc_lo && wr_lo[CDPC_SWITCH_REQUEST_BIT]) begin
                switch_request <= 1'b1;
                switch_count <= 8'h00;
            end
        end
    end

    // Reference output and power control registers
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            refclk_out_enable <= 1'b0;
            refclk_sleep_keep <= 1'b0;
            refclk_source_select <= 1'b0;
            refclk_divider <= 4'h0;
            primary_mode <= 1'b0;
            wdt_enable <= 1'b0;
            clock_fail_monitor_enable <= 1'b0;
        end else begin
            if (wr_refctl) begin
                refclk_out_enable <= PWDATA[CDPC_REFCLK_OUT_ENABLE_BIT];
                refclk_sleep_keep <= PWDATA[CDPC_REFCLK_SLEEP_KEEP_BIT];
                refclk_source_select <= PWDATA[CDPC_REFCLK_SOURCE_SELECT_BIT];
                refclk_divider <= PWDATA[CDPC_REFCLK_DIVIDER_LSB +: 4];
            end
            if (wr_pwrctl) begin
                primary_mode <= PWDATA[CDPC_PRIMODE_BIT];
                wdt_enable <= PWDATA[CDPC_WDTEN_BIT];
                clock_fail_monitor_enable <= PWDATA[CDPC_FSCMEN_BIT];
            end
        end
    end

    // Power mode; an interrupt seen during entry is held and wakes right after
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pmode <= CDPC_RUN;
            irq_held <= 1'b0;
            WAKE_TO_ISR <= 1'b0;
        end else begin
            WAKE_TO_ISR <= 1'b0;
            unique case (pmode)
                CDPC_RUN: begin
                    if (power_save_instruction_sleep || power_save_instruction_idle) begin
                        pmode <= power_save_instruction_sleep ? CDPC_SLEEP : CDPC_IDLE;
                        irq_held <= irq_rise;
                    end
                end
                CDPC_IDLE, CDPC_SLEEP: begin
                    irq_held <= 1'b0;
                    if (wake_event) begin
                        pmode <= CDPC_RUN;
                        WAKE_TO_ISR <= irq_rise || irq_held;
                    end
                end
                default: begin
                    pmode <= CDPC_RUN;
                end
            endcase
        end
    end

    // Primary oscillator input, synchronised before the edge detector
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pri_sync <= 3'b000;
        end else begin
            pri_sync <= {pri_sync[1:0], PRI_OSC_CLK};
        end
    end
    wire pri_edge = pri_sync[1] && !pri_sync[2];

    // Doze divider: CPU ticks every 2^ratio peripheral cycles
    wire doze_run = (pmode == CDPC_RUN) && cpu_slowdown_enable;
    wire doze_tick;
    cdpc_divider #(.WIDTH(DIV_WIDTH)) u_doze (
        .MCLK(MCLK),
        .NRST(NRST),
        .run(doze_run),
        .mask(pow2_mask({2'b00, doze_ratio})),
        .tick(doze_tick),
        .level()
    );

    // Postscaler code 111 is divide-by-256, not 128
    wire [4:0] rc_shift = (fast_rc_postscale == 3'h7) ? 5'd8 : {2'b00, fast_rc_postscale};
    wire rc_source = (active_source_select == CDPC_SRC_FRC) ||
                     (active_source_select == CDPC_SRC_FRC500);
    wire sys_tick;
    cdpc_divider #(.WIDTH(DIV_WIDTH)) u_post (
        .MCLK(MCLK),
        .NRST(NRST),
        .run(rc_source && !asleep),
        .mask(rc_source ? pow2_mask(rc_shift) : '0),
        .tick(sys_tick),
        .level()
    );

    // Reference output, source chosen per select bit
    wire ref_src_tick = refclk_source_select ? pri_edge : sys_tick;
    wire ref_allowed = !asleep || (refclk_sleep_keep && refclk_source_select && primary_mode);
    logic [DIV_WIDTH-1:0] ref_count;
    logic ref_level;
    wire [DIV_WIDTH-1:0] ref_mask = pow2_mask({1'b0, refclk_divider});
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ref_count <= '0;
            ref_level <= 1'b0;
        end else if (!(refclk_out_enable && ref_allowed)) begin
            ref_count <= '0;
            ref_level <= 1'b0;
        end else if (ref_src_tick) begin
            ref_count <= ref_count + 1'b1;
            if ((ref_count & ref_mask) == ref_mask) begin
                ref_level <= ~ref_level;
            end
        end
    end

    assign REFCLK_OUT_PIN = ref_level;
    assign REFCLK_OUT_OE = refclk_out_enable && ref_allowed;
    assign PRI_OSC_ON = !asleep || refclk_source_select;
    assign LOW_POWER_INTERNAL_RC_ON = pmode == CDPC_RUN || wdt_enable || clock_fail_monitor_enable;
    assign WDT_CLEAR = power_save_instruction_idle;
    assign CPU_CLK_EN = (pmode == CDPC_RUN) && (!cpu_slowdown_enable || doze_tick);
    assign PERIPH_CLK_EN = !asleep;

    // APB read mux
    wire [31:0] rd_clock_divider_control = {16'h0000, interrupt_speed_restore, doze_ratio,
                             cpu_slowdown_enable, fast_rc_postscale, 8'h00};
    wire [31:0] rd_oscctl = {17'h00000, active_source_select, 1'b0, next_source_select,
                             2'b00, pll_lock, 4'h0, switch_request};
    wire [31:0] rd_refctl = {16'h0000, refclk_out_enable, 1'b0, refclk_sleep_keep,
                             refclk_source_select, refclk_divider, 8'h00};
    wire [31:0] rd_pwrctl = {27'h0000000, clock_fail_monitor_enable, wdt_enable, primary_mode, 2'b00};
    wire [31:0] rd_status = {29'h00000000, irq_held, pmode};
    wire [31:0] rd_mux = addr_clock_divider_control ? rd_clock_divider_control :
                         addr_oscctl ? rd_oscctl :
                         addr_refctl ? rd_refctl :
                         addr_pwrctl ? rd_pwrctl :
                         addr_status ? rd_status : 32'h00000000;

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            PRDATA <= 32'h00000000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            PRDATA <= rd_mux;
        end
    end

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
endmodule

// ==== testbench/cdpc_top_asserts.sv ====
// Port-level properties of the clock control block
`timescale 1ns/1ps
module cdpc_top_asserts
    import cdpc_pkg::*;
#(
    parameter int DIV_WIDTH = 16
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic IRQ_EVENT,
    input wire logic WDT_TIMEOUT,
    input wire logic CPU_CLK_EN,
    input wire logic PERIPH_CLK_EN,
    input wire logic REFCLK_OUT_OE,
    input wire logic LOW_POWER_INTERNAL_RC_ON,
    input wire logic WDT_CLEAR,
    input wire logic WAKE_TO_ISR
);
    logic in_idle;
    wire logic wr_acc = PSEL && PENABLE && PWRITE;
    wire logic idle_wr = wr_acc && PADDR == CDPC_OFS_PWRCTL && PWDATA[1:0] == 2'h1;
    wire logic ref_wr = wr_acc && PADDR == CDPC_OFS_REFCTL;

    // Idle lasts from the entry write until the CPU clock comes back
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            in_idle <= 1'b0;
        end else begin
            in_idle <= idle_wr || (in_idle && !CPU_CLK_EN);
        end
    end

    default clocking dck @(posedge MCLK);
    endclocking
    default disable iff (!NRST);

    wdt_clear_a: assert property (idle_wr |-> WDT_CLEAR)
        else $error("watchdog not cleared on idle entry");
    cpu_halt_a: assert property (idle_wr |=> !CPU_CLK_EN)
        else $error("cpu clock still running in idle");
    periph_run_a: assert property (in_idle |-> PERIPH_CLK_EN)
        else $error("peripheral clock stopped in idle");
    low_power_internal_rc_keep_a: assert property (idle_wr && PWDATA[3] |=> LOW_POWER_INTERNAL_RC_ON [*2])
        else $error("low power oscillator off in idle");
    wdt_wake_a: assert property (in_idle && $rose(WDT_TIMEOUT) |-> ##[1:8] CPU_CLK_EN)
        else $error("no wake after watchdog timeout");
    irq_wake_a: assert property (in_idle && $rose(IRQ_EVENT) |-> ##[1:8] CPU_CLK_EN)
        else $error("no wake after interrupt");
    isr_entry_a: assert property (in_idle && $rose(IRQ_EVENT) |-> ##[1:8] WAKE_TO_ISR)
        else $error("no handler entry after interrupt wake");
    refclk_out_pin_on_a: assert property (ref_wr && PWDATA[15] |=> REFCLK_OUT_OE)
        else $error("reference pin not driven when enabled");
    refclk_out_pin_off_a: assert property (ref_wr && !PWDATA[15] |=> !REFCLK_OUT_OE)
        else $error("reference pin driven when disabled");

    idle_seen_c: cover property (idle_wr);
    irq_wake_c: cover property (in_idle && $rose(IRQ_EVENT));
    ref_on_c: cover property (ref_wr && PWDATA[15]);
endmodule

// ==== testbench/tb_cdpc_top.sv ====
// Self-checking bench for the clock control block
`timescale 1ns/1ps
module tb_cdpc_top import cdpc_pkg::*;;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} cdpc_row_t;
    logic MCLK, NRST, PSEL, PENABLE, PWRITE, IRQ_EVENT, WDT_TIMEOUT, PLL_LOCK, PRI_OSC_CLK;
    logic [7:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [3:0] PSTRB;
    logic PREADY, PSLVERR, CPU_CLK_EN, PERIPH_CLK_EN, REFCLK_OUT_PIN, REFCLK_OUT_OE, er;
    logic PRI_OSC_ON, LOW_POWER_INTERNAL_RC_ON, WDT_CLEAR, WAKE_TO_ISR;
    int n_fail = 0;
    int comparisons = 0;
    int hi, tg, n_wake;
    cdpc_row_t rows [7] = '{'{8'h00, 32'hFFFF_F7FF, 32'h0000_F700, 1'b0},
        '{8'h00, 32'hFFFF_08FF, 32'h0000_0800, 1'b0}, '{8'h08, 32'hFFFF_FFFF, 32'h0000_BF00, 1'b0},
        '{8'h08, 32'h0, 32'h0, 1'b0}, '{8'h10, 32'hFFFF_FFFF, 32'h0, 1'b0},
        '{8'h14, 32'hFFFF_FFFF, 32'h0, 1'b1}, '{8'h04, 32'h0000_0500, 32'h0000_7700, 1'b0}};

    cdpc_top #(.DIV_WIDTH(16)) dut (
        .MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .IRQ_EVENT(IRQ_EVENT), .WDT_TIMEOUT(WDT_TIMEOUT),
        .PLL_LOCK(PLL_LOCK), .PRI_OSC_CLK(PRI_OSC_CLK), .CPU_CLK_EN(CPU_CLK_EN),
        .PERIPH_CLK_EN(PERIPH_CLK_EN), .REFCLK_OUT_PIN(REFCLK_OUT_PIN),
        .REFCLK_OUT_OE(REFCLK_OUT_OE), .PRI_OSC_ON(PRI_OSC_ON), .LOW_POWER_INTERNAL_RC_ON(LOW_POWER_INTERNAL_RC_ON),
        .WDT_CLEAR(WDT_CLEAR), .WAKE_TO_ISR(WAKE_TO_ISR)
    );

    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end

    // Slow primary oscillator, one rising edge every 8 system cycles
    initial begin
        PRI_OSC_CLK = 1'b0;
        forever begin
            repeat (4) @(posedge MCLK);
            PRI_OSC_CLK <= ~PRI_OSC_CLK;
        end
    end

    // Handler entry is a one-cycle pulse, so it is counted rather than polled
    always @(posedge MCLK) if (WAKE_TO_ISR === 1'b1) n_wake++;

    initial begin
        #2400000;
        n_fail++;
        $display("Error run_limit expected finish seen hang");
        conclude();
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic w);
        int k;
        k = 0;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PADDR <= a;
        PWDATA <= d;
        PSTRB <= s;
        PWRITE <= w;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge MCLK);
            k++;
        end while (PREADY !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_fail++;
            $display("Error pready expected 1 seen 0");
            conclude();
        end
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge MCLK);
    endtask

    task automatic measure();
        logic last;
        hi = 0;
        tg = 0;
        last = REFCLK_OUT_PIN;
        repeat (256) begin
            @(negedge MCLK);
            hi += int'(CPU_CLK_EN === 1'b1);
            tg += int'(REFCLK_OUT_PIN !== last);
            last = REFCLK_OUT_PIN;
        end
        @(posedge MCLK);
    endtask

    function automatic logic near(input int v, input int e);
        return v >= e - 2 && v <= e + 2;
    endfunction

    // Waits for the CPU clock (0), a handler entry (1) or the peripheral clock (2)
    task automatic waitsig(input int w);
        int k;
        int base;
        k = 0;
        base = n_wake;
        comparisons++;
        while (!(w == 0 ? CPU_CLK_EN === 1'b1 : w == 1 ? n_wake != base
                 : PERIPH_CLK_EN === 1'b1)) begin
            @(negedge MCLK);
            k++;
            if (k > 64) begin
                n_fail++;
                $display("Error wake_%0d expected within 64 cycles seen none", w);
                conclude();
            end
        end
        @(posedge MCLK);
    endtask

    task automatic switch_to(input logic [31:0] src, input logic [31:0] k1);
        apb(CDPC_OFS_OSCCTL, k1, 4'h2, 1'b1);
        apb(CDPC_OFS_OSCCTL, 32'h9A00, 4'h2, 1'b1);
        apb(CDPC_OFS_OSCCTL, src << 8, 4'h2, 1'b1);
        apb(CDPC_OFS_OSCCTL, 32'h46, 4'h1, 1'b1);
        apb(CDPC_OFS_OSCCTL, 32'h57, 4'h1, 1'b1);
        apb(CDPC_OFS_OSCCTL, 32'h01, 4'h1, 1'b1);
        apb(CDPC_OFS_OSCCTL, 32'h0, 4'hF, 1'b0);
    endtask

    initial begin
        NRST = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h0;
        PWDATA = 32'h0;
        PSTRB = 4'h0;
        IRQ_EVENT = 1'b0;
        WDT_TIMEOUT = 1'b0;
        PLL_LOCK = 1'b0;
        repeat (16) @(posedge MCLK);
        check("oe_reset", REFCLK_OUT_OE, 32'h0);
        check("cpu_reset", CPU_CLK_EN, 32'h1);
        NRST <= 1'b1;
        @(posedge MCLK);
        apb(CDPC_OFS_CLOCK_DIVIDER_CONTROL, 32'h0, 4'hF, 1'b0);
        check("clock_divider_control_reset", rd, 32'h3100);
        foreach (rows[i]) begin
            apb(rows[i].a, rows[i].d, 4'hF, 1'b1);
            apb(rows[i].a, 32'h0, 4'hF, 1'b0);
            check("row_data", rd, rows[i].e);
            check("row_err", er, rows[i].err);
        end
        $display("register rows done");
        for (int c = 0; c < 9; c++) begin
            apb(CDPC_OFS_CLOCK_DIVIDER_CONTROL, c < 8 ? 32'h0800 | (c << 12) : 32'h7000, 4'hF, 1'b1);
            measure();
            check("doze_ratio", near(hi, c < 8 ? 256 >> c : 256), 32'h1);
        end
        for (int r = 1; r >= 0; r--) begin
            apb(CDPC_OFS_CLOCK_DIVIDER_CONTROL, r ? 32'hF800 : 32'h7800, 4'hF, 1'b1);
            IRQ_EVENT <= 1'b1;
            repeat (6) @(posedge MCLK);
            IRQ_EVENT <= 1'b0;
            apb(CDPC_OFS_CLOCK_DIVIDER_CONTROL, 32'h0, 4'hF, 1'b0);
            check("restore_enable", rd[11], r ? 32'h0 : 32'h1);
            measure();
            check("restore_ratio", near(hi, r ? 256 : 2), 32'h1);
        end
        apb(CDPC_OFS_CLOCK_DIVIDER_CONTROL, 32'h3100, 4'hF, 1'b1);
        $display("doze tests done");
        for (int k = 0; k < 2; k++) begin
            switch_to(32'h6, k ? 32'h7900 : 32'h9A00);
            apb(CDPC_OFS_OSCCTL, 32'h0, 4'hF, 1'b0);
            // Low unlock is still valid: request sets, source stays, no lock yet
            check("osc_locked", rd, 32'h7701);
        end
        PLL_LOCK <= 1'b1;
        repeat (4) @(posedge MCLK);
        switch_to(32'h6, 32'h7800);
        check("switch_pending", rd[0], 32'h1);
        for (int j = 0; j < 30 && rd[0] !== 1'b0; j++) apb(CDPC_OFS_OSCCTL, 32'h0, 4'hF, 1'b0);
        check("switch_done", rd, 32'h6620);
        PLL_LOCK <= 1'b0;
        repeat (4) @(posedge MCLK);
        switch_to(32'h7, 32'h7800);
        repeat (40) @(posedge MCLK);
        apb(CDPC_OFS_OSCCTL, 32'h0, 4'hF, 1'b0);
        check("switch_stuck", rd & 32'h21, 32'h01);
        PLL_LOCK <= 1'b1;
        $display("clock switch tests done");
        for (int v = 0; v < 6; v++) begin
            apb(CDPC_OFS_REFCTL, v < 5 ? 32'h8000 | (v << 8) : 32'h9000, 4'hF, 1'b1);
            check("ref_oe", REFCLK_OUT_OE, 32'h1);
            measure();
            // System ticks come through the divide-by-2 postscaler
            check("ref_rate", near(tg, v < 5 ? 128 >> v : 32), 32'h1);
        end
        for (int k = 0; k < 2; k++) begin
            apb(CDPC_OFS_REFCTL, k ? 32'h8000 : 32'hB000, 4'hF, 1'b1);
            apb(CDPC_OFS_PWRCTL, 32'h06, 4'hF, 1'b1);
            check("sleep_oe", REFCLK_OUT_OE, k ? 32'h0 : 32'h1);
            check("sleep_pri", PRI_OSC_ON, k ? 32'h0 : 32'h1);
            IRQ_EVENT <= 1'b1;
            waitsig(2);
            IRQ_EVENT <= 1'b0;
            repeat (4) @(posedge MCLK);
        end
        $display("reference and sleep tests done");
        apb(CDPC_OFS_PWRCTL, 32'h09, 4'hF, 1'b1);
        check("idle_cpu", CPU_CLK_EN, 32'h0);
        check("idle_low_power_internal_rc", LOW_POWER_INTERNAL_RC_ON, 32'h1);
        hi = n_wake;
        WDT_TIMEOUT <= 1'b1;
        waitsig(0);
        WDT_TIMEOUT <= 1'b0;
        check("wdt_no_isr", n_wake, hi);
        for (int k = 0; k < 2; k++) begin
            // Second pass lands the synchronised edge on the entry write itself
            if (k == 1) begin
                IRQ_EVENT <= 1'b1;
                @(posedge MCLK);
            end
            apb(CDPC_OFS_PWRCTL, 32'h01, 4'hF, 1'b1);
            if (k == 0) check("idle_low_power_internal_rc_off", LOW_POWER_INTERNAL_RC_ON, 32'h0);
            IRQ_EVENT <= 1'b1;
            waitsig(1);
            IRQ_EVENT <= 1'b0;
            repeat (4) @(posedge MCLK);
        end
        apb(CDPC_OFS_PWRCTL, 32'h01, 4'hF, 1'b1);
        NRST <= 1'b0;
        repeat (2) @(posedge MCLK);
        NRST <= 1'b1;
        @(negedge MCLK);
        check("reset_wake", CPU_CLK_EN, 32'h1);
        $display("idle tests done");
        conclude();
    end
endmodule

bind cdpc_top cdpc_top_asserts #(.DIV_WIDTH(DIV_WIDTH)) u_chk (
    .MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .IRQ_EVENT(IRQ_EVENT), .WDT_TIMEOUT(WDT_TIMEOUT),
    .CPU_CLK_EN(CPU_CLK_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN), .REFCLK_OUT_OE(REFCLK_OUT_OE),
    .LOW_POWER_INTERNAL_RC_ON(LOW_POWER_INTERNAL_RC_ON), .WDT_CLEAR(WDT_CLEAR), .WAKE_TO_ISR(WAKE_TO_ISR)
);
